// file: spf_front.sv
// SPI slave command front end: framing, mode detect, opcode decode, address
// intake, write enable latch, status register and a two-entry write buffer.
// Assumes SPI pins are asynchronous to clock; serial clock at most clock/8.
`timescale 1ns/1ns
`include "spf_regs.svh"

module spf_front (
  input  wire logic        clock,             // System clock, 20 MHz
  input  wire logic        rst,               // Asynchronous reset, high
  input  wire logic        cs_n_pin,          // Chip select pin, low selects
  input  wire logic        sck_pin,           // Serial clock pin
  input  wire logic        si_pin,            // Serial data in pin
  output logic             so,                // Serial data out level
  output logic             so_oe_n,           // Serial out enable, low drives
  output logic [7:0]       opcode_out,        // Last valid opcode
  output logic             opcode_strobe,     // Valid opcode decoded pulse
  output logic [16:0]      addr_out,          // Significant address bits
  output logic             addr_strobe,       // Address complete pulse
  output logic [7:0]       status_out,        // Status register contents
  output logic             write_enable_flag, // Write enable latch
  output logic             spi_mode3,         // Current frame runs mode 3
  output logic [7:0]       data_out,          // Written byte at buffer head
  output logic             data_valid,        // Buffer head holds a byte
  input  wire logic        data_ready,        // Sink takes the head byte
  output logic             data_overrun       // Byte lost, buffer full pulse
);

  spf_pkg::spf_state_s r;       // Registered state
  spf_pkg::spf_state_s next_r;  // Next state

  // Filtered level updates and the edges they produce
  logic       cs_agree;   // Chip select stages agree
  logic       sck_agree;  // Clock stages agree
  logic       si_now;     // Serial input level this cycle
  logic       cs_fall;    // Frame start
  logic       cs_rise;    // Frame end
  logic       sck_rise;   // Sampling edge
  logic       sck_fall;   // Output edge
  logic [7:0] byte_in;    // Byte completed by this sample

  // Combinational next state
  always_comb begin
    next_r = r;
    // Pulses last one cycle
    next_r.op_stb = 1'b0;
    next_r.addr_stb = 1'b0;
    next_r.ovr = 1'b0;

    // Three-stage synchronisers; only the later two stages are compared
    next_r.cs_sy = {r.cs_sy[1:0], cs_n_pin};
    next_r.sck_sy = {r.sck_sy[1:0], sck_pin};
    next_r.si_sy = {r.si_sy[1:0], si_pin};
    cs_agree = (r.cs_sy[1] == r.cs_sy[2]);
    sck_agree = (r.sck_sy[1] == r.sck_sy[2]);
    si_now = (r.si_sy[1] == r.si_sy[2]) ? r.si_sy[2] : r.si;
    next_r.si = si_now;
    if (cs_agree) begin
      next_r.cs_n = r.cs_sy[2];
    end
    if (sck_agree) begin
      next_r.sck = r.sck_sy[2];
    end
    cs_fall = cs_agree & ~r.cs_sy[2] & r.cs_n;
    cs_rise = cs_agree & r.cs_sy[2] & ~r.cs_n;
    sck_rise = sck_agree & r.sck_sy[2] & ~r.sck;
    sck_fall = sck_agree & ~r.sck_sy[2] & r.sck;
    byte_in = {r.shreg[6:0], si_now}; // R09

    // Buffer drain first, so a pop frees room for a push in the same cycle
    if (r.out_valid && data_ready) begin
      next_r.out_valid = r.skid_valid;
      next_r.out_data = r.skid_data;
      next_r.skid_valid = 1'b0;
    end

    if (cs_fall) begin // R20
      // Only the master's select opens a frame; nothing here starts one
      // Clock level at select fixes the mode for this frame
      next_r.mode3 = r.sck; // R03
      // Mode 3 waits for the clock to go low before counting rises
      next_r.armed = ~r.sck; // R04
      next_r.phase = spf_pkg::SPF_OPCODE; // R06 R07
      next_r.bit_cnt = '0;
      next_r.byte_cnt = '0;
      next_r.clr_pend = 1'b0;
      next_r.so_oe_n = 1'b1;
    end else if (cs_rise) begin
      // Deselect ends any command; bits of a partial address byte stay shifted into addr_out
      next_r.phase = spf_pkg::SPF_IDLE; // R25
      next_r.so_oe_n = 1'b1; // R08
      next_r.clr_pend = 1'b0;
      if (r.clr_pend) begin
        next_r.status[`SPF_WRITE_ENABLE_BIT] = 1'b0; // R18 R23
      end
    end else if (r.phase != spf_pkg::SPF_IDLE) begin
      // Output edge: arms mode 3 and moves the status byte out
      if (sck_fall) begin
        next_r.armed = 1'b1; // R04
        if (r.phase == spf_pkg::SPF_STAT_RD) begin
          next_r.so = r.out_shift[7]; // R02 R09
          next_r.so_oe_n = 1'b0;
          next_r.out_shift = {r.out_shift[6:0], r.out_shift[7]};
        end
      end
      // Sampling edge: shift in, act at each byte boundary
      if (sck_rise && r.armed) begin // R01
        next_r.shreg = byte_in;
        next_r.bit_cnt = r.bit_cnt + 3'h1;
        if (r.phase == spf_pkg::SPF_ADDR) begin
          // Shifting keeps only the low bits; the first seven fall off
          next_r.addr = {r.addr[15:0], si_now}; // R10
        end
        if (r.bit_cnt == `SPF_LAST_BIT) begin
          unique case (r.phase)
            spf_pkg::SPF_OPCODE: begin
              // Decode as soon as the eighth bit is in
              next_r.opcode = byte_in; // R24
              next_r.op_stb = 1'b1;
              next_r.phase = spf_pkg::SPF_SINK;
              case (byte_in)
                `SPF_OP_LATCH_SET: begin
                  next_r.status[`SPF_WRITE_ENABLE_BIT] = 1'b1; // R16 R13
                end
                `SPF_OP_LATCH_CLEAR: begin
                  next_r.clr_pend = 1'b1; // R23 R13
                end
                `SPF_OP_STATUS_RD: begin
                  next_r.out_shift = r.status; // R21 R13
                  next_r.phase = spf_pkg::SPF_STAT_RD;
                end
                `SPF_OP_STATUS_WR: begin
                  next_r.clr_pend = 1'b1; // R18 R13
                  next_r.phase = spf_pkg::SPF_STAT_WR;
                end
                `SPF_OP_MEM_RD, `SPF_OP_FAST_RD: begin
                  next_r.phase = spf_pkg::SPF_ADDR; // R13 R14
                end
                `SPF_OP_MEM_WR: begin
                  next_r.clr_pend = 1'b1; // R18 R14
                  next_r.phase = spf_pkg::SPF_ADDR;
                end
                `SPF_OP_SLEEP, `SPF_OP_IDENT_RD, `SPF_OP_SERIAL_RD: begin
                  next_r.phase = spf_pkg::SPF_SINK; // R14
                end
                default: begin
                  // Unknown code: no action, SO stays off until reselect
                  next_r.opcode = r.opcode; // R12
                  next_r.op_stb = 1'b0;
                  next_r.phase = spf_pkg::SPF_INVALID;
                end
              endcase
            end
            spf_pkg::SPF_ADDR: begin
              if (r.byte_cnt == `SPF_LAST_ADDR_BYTE) begin
                next_r.addr_stb = 1'b1; // R10
                next_r.phase = (r.opcode == `SPF_OP_MEM_WR) ?
                               spf_pkg::SPF_WDATA : spf_pkg::SPF_SINK;
              end else begin
                next_r.byte_cnt = r.byte_cnt + 2'h1;
              end
            end
            spf_pkg::SPF_WDATA: begin
              // Writes pass only with the latch set; a full buffer drops
              if (r.status[`SPF_WRITE_ENABLE_BIT]) begin // R16
                if (!next_r.out_valid) begin
                  next_r.out_valid = 1'b1;
                  next_r.out_data = byte_in;
                end else if (!next_r.skid_valid) begin
                  next_r.skid_valid = 1'b1;
                  next_r.skid_data = byte_in;
                end else begin
                  next_r.ovr = 1'b1;
                end
              end
            end
            spf_pkg::SPF_STAT_WR: begin
              // Only writable fields change; enable flag and fixed bits hold
              if (r.status[`SPF_WRITE_ENABLE_BIT]) begin // R16
                next_r.status = (byte_in & `SPF_STATUS_WMASK) |
                                (r.status & ~`SPF_STATUS_WMASK); // R17
              end
              next_r.phase = spf_pkg::SPF_SINK;
            end
            spf_pkg::SPF_STAT_RD, spf_pkg::SPF_SINK,
            spf_pkg::SPF_INVALID, spf_pkg::SPF_IDLE: begin
              // Further bytes carry nothing for this block
              next_r.phase = r.phase; // R12
            end
          endcase
        end
      end
    end
  end

  // State register; the latch powers up cleared and SO off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.cs_sy <= `SPF_SYNC_IDLE_HIGH;
      r.cs_n <= 1'b1;
      r.so_oe_n <= 1'b1; // R08
      r.status <= `SPF_STATUS_RESET; // R15
    end else begin
      r <= next_r;
    end
  end

  // Outputs are fields of the state register
  assign so = r.so;
  assign so_oe_n = r.so_oe_n;
  assign opcode_out = r.opcode;
  assign opcode_strobe = r.op_stb;
  assign addr_out = r.addr;
  assign addr_strobe = r.addr_stb;
  assign status_out = r.status;
  assign write_enable_flag = r.status[`SPF_WRITE_ENABLE_BIT]; // R22
  assign spi_mode3 = r.mode3;
  assign data_out = r.out_data;
  assign data_valid = r.out_valid;
  assign data_overrun = r.ovr;

endmodule

// file: spf_regs.svh
// Constants of the SPI slave command front end: opcodes, status fields, counts.
// Assumes the includer works on one system clock with all SPI pins sampled.
// Summary of operation
// R01: Support modes 0 and 3, sample SI rising.
// R02: Change SO on falling serial clock edges.
// R03: Clock level at select picks mode.
// R04: Mode 3 counts rising edges after clock low.
// R05: Master idles clock per selected mode.
// R06: First byte after select is the opcode.
// R07: One opcode per select; new command needs select.
// R08: Deselected: ignore SI, SO high impedance.
// R09: All bytes shift most significant bit first.
// R10: Three address bytes, keep low 17 bits.
// R11: Master should send zero upper address bits.
// R12: Invalid opcode: ignore rest, SO tristated.
// R13: Decode set, clear, status, write, read opcodes.
// R14: Decode fast read, write, sleep, ident, serial.
// R15: Write enable latch cleared at power up.
// R16: Latch set opcode sets the enable latch.
// R17: Status write cannot change the enable flag.
// R18: Deselect after clear/status/memory write clears latch.
// R19: Master waits power up delay first.
// R20: Device never starts a transfer itself.
// R21: Hold an 8-bit configuration/status register.
// R22: Enable latch shows at status bit one.
// R23: Latch clear command disables all writes.
// R24: Decode opcode after eighth sampled bit.
// R25: Deselect mid byte aborts without side effects; addr_out keeps any partly shifted address bits.
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

`define SPF_OP_LATCH_SET   8'h06
`define SPF_OP_LATCH_CLEAR 8'h04
`define SPF_OP_STATUS_RD   8'h05
`define SPF_OP_STATUS_WR   8'h01
`define SPF_OP_MEM_RD      8'h03
`define SPF_OP_FAST_RD     8'h0B
`define SPF_OP_MEM_WR      8'h02
`define SPF_OP_SLEEP       8'hB9
`define SPF_OP_IDENT_RD    8'h9F
`define SPF_OP_SERIAL_RD   8'hC3

`define SPF_STATUS_RESET   8'h40
`define SPF_STATUS_WMASK   8'h8C
`define SPF_WRITE_ENABLE_BIT 1
`define SPF_LAST_BIT       3'h7
`define SPF_LAST_ADDR_BYTE 2'h2
`define SPF_SYNC_IDLE_HIGH 3'h7

`endif

// file: spf_pkg.sv
// Types of the SPI slave command front end: frame phases and the state record.
// Assumes spf_regs.svh is compiled in the same unit for field constants.
package spf_pkg;

  // Where the frame stands: idle, in the opcode byte, or after it
  typedef enum logic [2:0] {
    SPF_IDLE,
    SPF_OPCODE,
    SPF_ADDR,
    SPF_WDATA,
    SPF_STAT_RD,
    SPF_STAT_WR,
    SPF_SINK,
    SPF_INVALID
  } spf_phase_e;

  // Whole state of the front end
  typedef struct packed {
    logic [2:0]  cs_sy;      // Chip select synchroniser
    logic [2:0]  sck_sy;     // Serial clock synchroniser
    logic [2:0]  si_sy;      // Serial input synchroniser
    logic        cs_n;       // Filtered chip select level
    logic        sck;        // Filtered serial clock level
    logic        si;         // Filtered serial input level
    logic        mode3;      // Frame runs in mode 3
    logic        armed;      // Rising edges now count
    spf_phase_e  phase;      // Frame phase
    logic [2:0]  bit_cnt;    // Bits of current byte
    logic [1:0]  byte_cnt;   // Address bytes taken
    logic [7:0]  shreg;      // Input shifter
    logic [7:0]  opcode;     // Decoded opcode
    logic [16:0] addr;       // Significant address bits
    logic [7:0]  status;     // Status register
    logic [7:0]  out_shift;  // Output shifter
    logic        so;         // Serial output level
    logic        so_oe_n;    // Serial output enable, low drives
    logic        clr_pend;   // Latch clears at deselect
    logic        op_stb;     // Opcode accepted pulse
    logic        addr_stb;   // Address complete pulse
    logic        ovr;        // Byte dropped pulse
    logic        out_valid;  // Buffer head valid
    logic [7:0]  out_data;   // Buffer head byte
    logic        skid_valid; // Buffer second entry valid
    logic [7:0]  skid_data;  // Buffer second entry byte
  } spf_state_s;

endpackage

// file: spf_front_checker.sv
// Concurrent checks on the ports of the SPI slave command front end.
// Assumes one clock domain; bound into every spf_front instance.
`timescale 1ns/1ns

module spf_front_checker (
  input wire logic        clock,             // System clock
  input wire logic        rst,               // Async reset, high
  input wire logic        cs_n_pin,          // Chip select pin
  input wire logic        so_oe_n,           // SO enable, low drives
  input wire logic [7:0]  opcode_out,        // Last valid opcode
  input wire logic        opcode_strobe,     // Opcode pulse
  input wire logic        addr_strobe,       // Address pulse
  input wire logic [7:0]  status_out,        // Status register
  input wire logic        write_enable_flag, // Enable latch
  input wire logic [7:0]  data_out,          // Buffer head
  input wire logic        data_valid,        // Head valid
  input wire logic        data_ready,        // Sink ready
  input wire logic        data_overrun       // Lost byte pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Long enough for the pin synchroniser to settle
  sequence s_deselected;
    cs_n_pin [*6];
  endsequence
  property p_oe_idle;
    s_deselected |-> so_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("SO enabled while deselected");
  property p_quiet;
    s_deselected |-> !opcode_strobe && !addr_strobe && !data_overrun;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Activity while deselected");
  property p_opcode_valid;
    opcode_strobe |=> opcode_out inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03,
                                         8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hC3};
  endproperty
  a_opcode_valid: assert property (p_opcode_valid) else $error("Bad opcode");
  property p_latch_bit;
    write_enable_flag == status_out[1];
  endproperty
  a_latch_bit: assert property (p_latch_bit) else $error("Latch not at bit 1");
  property p_status_fixed;
    status_out[6] && status_out[5:4] == 2'h0 && !status_out[0];
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("Fixed bits");
  property p_latch_set;
    $rose(write_enable_flag) |-> opcode_out == 8'h06;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("Latch set by other");
  // Clearing only follows a seen deselect
  property p_latch_clear;
    $fell(write_enable_flag) |-> $past(cs_n_pin) && $past(cs_n_pin, 2) && $past(cs_n_pin, 3);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("Latch cleared in frame");
  property p_oe_status;
    $fell(so_oe_n) |-> opcode_out == 8'h05;
  endproperty
  a_oe_status: assert property (p_oe_status) else $error("SO driven off status");
  property p_hold;
    data_valid && !data_ready |=> data_valid && $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("Head byte lost");
endmodule

bind spf_front spf_front_checker u_chk (.clock, .rst, .cs_n_pin, .so_oe_n, .opcode_out,
  .opcode_strobe, .addr_strobe, .status_out, .write_enable_flag, .data_out, .data_valid,
  .data_ready, .data_overrun);

// file: spf_master.sv
// SPI bus master model: chip select, 400 ns serial clock and data in.
// Assumes the bench clock runs; sel starts on its falling edge.
`timescale 1ns/1ns

module spf_master (
  input  wire logic clock,   // Bench clock, for alignment
  input  wire logic so,      // Device serial out
  input  wire logic so_oe_n, // Device output enable, low drives
  output logic      cs_n,    // Chip select, low selects
  output logic      sck,     // Serial clock
  output logic      si       // Serial data to device
);
  logic m3; // Frame runs mode 3
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    m3   = 1'b0;
  end
  // Clock settles at its idle level before select
  task automatic sel(input logic mode3);
    @(negedge clock);
    m3  = mode3;
    sck = mode3;
    #400;
    cs_n = 1'b0;
    #200;
  endtask
  // MSB first; SO read late in the high half, clear of the device's update
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si  = tx[i];
      #200;
      sck = 1'b1;
      #190;
      rx[i] = so_oe_n ? ~si : so;
      #10;
    end
  endtask
  // Released data line flips so a stale level is never trusted
  task automatic desel();
    if (!m3) sck = 1'b0;
    #200;
    cs_n = 1'b1;
    si   = ~si;
    #400;
  endtask
endmodule

// file: tb_spf_front.sv
// Self-checking bench of the SPI slave command front end.
// Assumes spf_master drives the pins and the checker is bound.
`timescale 1ns/1ns

module tb_spf_front;
  logic        clock, rst, data_ready;          // Bench driven
  logic        cs_n, sck, si, so, so_oe_n;      // SPI pins
  logic [7:0]  opcode_out, status_out, data_out; // Device bytes
  logic        opcode_strobe, addr_strobe, write_enable_flag, spi_mode3;
  logic        data_valid, data_overrun;         // Buffer flags
  logic [16:0] addr_out;                         // Address
  logic [7:0]  rx, prev;                         // Read back byte
  int          n_errors, n_compared, n_ovr, n_oe; // Counters
  logic [7:0]  ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03,
                            8'h0B, 8'h02, 8'hB9, 8'h9F, 8'hC3};

  spf_front dut (.clock, .rst, .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .so, .so_oe_n,
    .opcode_out, .opcode_strobe, .addr_out, .addr_strobe, .status_out, .write_enable_flag,
    .spi_mode3, .data_out, .data_valid, .data_ready, .data_overrun);
  spf_master u_m (.clock, .so, .so_oe_n, .cs_n, .sck, .si);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Pulses are counted mid-cycle, clear of the edge that launches them
  always @(negedge clock) begin
    if (data_overrun === 1'b1) n_ovr++;
    if (so_oe_n === 1'b0) n_oe++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic m, input logic [7:0] op, input logic [7:0] b);
    u_m.sel(m);
    u_m.xfer(op, rx);
    u_m.xfer(b, rx);
    u_m.desel();
  endtask
  // Every opcode in mode 0; status read after the clear
  task automatic t_opcodes();
    for (int i = 0; i < 10; i++) begin
      frame(1'b0, ops[i], 8'h00);
      check(opcode_out, ops[i]);
      if (i == 0) check(write_enable_flag, 1'b1);
      if (i == 1) check(write_enable_flag, 1'b0);
      if (i == 2) check(rx, 8'h40);
    end
  endtask
  task automatic t_status_write();
    frame(1'b0, 8'h06, 8'h00);
    u_m.sel(1'b0);
    u_m.xfer(8'h01, rx);
    u_m.xfer(8'hFF, rx);
    #400;
    check(status_out, 8'hCE);
    u_m.desel();
    check(status_out, 8'hCC);
  endtask
  // Mode 3 write with the sink stalled until after the frame
  task automatic t_mem_write();
    frame(1'b1, 8'h06, 8'h00);
    check({spi_mode3, write_enable_flag}, 2'h3);
    u_m.sel(1'b1);
    u_m.xfer(8'h02, rx);
    // Upper address bits sent as ones on purpose; zeros are only advised
    u_m.xfer(8'hFF, rx);
    u_m.xfer(8'h21, rx);
    u_m.xfer(8'h34, rx);
    check(addr_out, 17'h12134);
    u_m.xfer(8'hA5, rx);
    u_m.xfer(8'h3C, rx);
    u_m.xfer(8'h0F, rx);
    u_m.desel();
    check(n_ovr, 32'h1);
    check(data_out, 8'hA5);
    check(write_enable_flag, 1'b0);
    @(negedge clock) data_ready = 1'b1;
    @(negedge clock) check(data_out, 8'h3C);
    @(negedge clock) check(data_valid, 1'b0);
    data_ready = 1'b0;
    // Mode 3 write of 77 to address 0 with the latch now clear: nothing may reach the buffer
    u_m.sel(1'b1);
    u_m.xfer(8'h02, rx);
    u_m.xfer(8'h00, rx);
    u_m.xfer(8'h00, rx);
    u_m.xfer(8'h00, rx);
    u_m.xfer(8'h77, rx);
    u_m.desel();
    check(data_valid, 1'b0);
  endtask
  // Unknown opcode: nothing decoded, SO never driven
  task automatic t_invalid();
    prev = opcode_out;
    n_oe = 0;
    frame(1'b0, 8'hFF, 8'h05);
    check(opcode_out, prev);
    check(n_oe, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    rst        = 1'b1;
    data_ready = 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    check({status_out, write_enable_flag}, {8'h40, 1'b0});
    t_opcodes();
    t_status_write();
    t_mem_write();
    t_invalid();
    tally_and_finish();
  end
endmodule
